// ==== ild_defs.vh ====
// constants for the instruction length decoder: opcode classes and lengths
`ifndef ILD_DEFS_VH
`define ILD_DEFS_VH

// opcode byte = {class[4:0], variant[2:0]}
`define ILD_CLS_MSB       7
`define ILD_CLS_LSB       3
`define ILD_VAR_MSB       2
`define ILD_VAR_LSB       0
`define ILD_VAR_LONG      2
`define ILD_VAR_BYTE      0

// instruction lengths in bytes
`define ILD_LEN2          3'h2
`define ILD_LEN4          3'h4

// instruction classes
`define ILD_C_ADD         5'h00
`define ILD_C_SUB         5'h01
`define ILD_C_MUL         5'h02
`define ILD_C_DIV         5'h03
`define ILD_C_CPLNEG      5'h04
`define ILD_C_AND         5'h05
`define ILD_C_OR          5'h06
`define ILD_C_XOR         5'h07
`define ILD_C_BITCS       5'h08
`define ILD_C_BITMOV      5'h09
`define ILD_C_BITLOG      5'h0A
`define ILD_C_BFMOD       5'h0B
`define ILD_C_CMP         5'h0C
`define ILD_C_CMPSTEP     5'h0D
`define ILD_C_NORM        5'h0E
`define ILD_C_SHIFT       5'h0F
`define ILD_C_MOV         5'h10
`define ILD_C_MOVEXT      5'h11
`define ILD_C_JUMP        5'h12
`define ILD_C_BITJMP      5'h13
`define ILD_C_CALL        5'h14
`define ILD_C_CTXSW       5'h15
`define ILD_C_PUSHPOP     5'h16
`define ILD_C_RETURN      5'h17
`define ILD_C_TRAP        5'h18
`define ILD_C_SYSCTL      5'h19
`define ILD_C_EXTPFX      5'h1A
`define ILD_C_NOP         5'h1B
`define ILD_C_COPROC      5'h1C

// system control variant that is decoded but has no effect
`define ILD_SYS_LEGACY_POWERDOWN_OP     3'h2

// extension prefix kinds (variant[1:0])
`define ILD_EXT_PAGE      2'h0
`define ILD_EXT_SEG       2'h1
`define ILD_EXT_REG       2'h2
`define ILD_EXT_ATOMIC    2'h3

// jump condition codes (operand byte [7:4])
`define ILD_CC_UC         4'h0
`define ILD_CC_Z          4'h1
`define ILD_CC_NZ         4'h2
`define ILD_CC_C          4'h3
`define ILD_CC_NC         4'h4
`define ILD_CC_N          4'h5
`define ILD_CC_NN         4'h6
`define ILD_CC_V          4'h7
`define ILD_CC_NV         4'h8

// flag bit positions of i_flags
`define ILD_FLG_Z         0
`define ILD_FLG_C         1
`define ILD_FLG_N         2
`define ILD_FLG_V         3

// reset values
`define ILD_RST_CLS       5'h1B
`define ILD_RST_CNT       3'h0

`endif

// ==== ild_decoder.v ====
// instruction class and length decoder between fetch and execute
`timescale 1ns/1ns
// Behaviour
// RULE_01: add/subtract, word/byte, carry, 2 or 4 bytes
// RULE_02: signed/unsigned register by register multiply
// RULE_03: divide low muldiv register, 2 bytes
// RULE_04: long divide of register pair, 2 bytes
// RULE_05: complement or negate register, 2 bytes
// RULE_06: bit clear/set 2; bit move/logic 4
// RULE_07: masked high/low byte modify, 4 bytes
// RULE_08: compare then step register by 1/2
// RULE_09: normalize count instruction, 2 bytes
// RULE_10: shifts, rotates, sign shift, 2 bytes
// RULE_11: byte to word sign/zero extend move
// RULE_12: jumps taken only on met condition, 4 bytes; variant 3 is taken whatever the condition
// RULE_13: bit-test relative branches, optional bit modify
// RULE_14: context switch push and load, 4 bytes
// RULE_15: near, far, interrupt returns, 2 bytes
// RULE_16: trap with immediate number, 2 bytes
// RULE_17: extension prefixes open a sequence
// RULE_18: legacy power-down decodes, does nothing
// RULE_19: report length 2 or 4 to fetch
`include "ild_defs.vh"

module ild_decoder (
  input  wire        i_mclk,       // system clock
  input  wire        i_reset,      // synchronous reset, active high
  input  wire        i_valid,      // opcode word present this cycle
  input  wire [15:0] i_opword,     // first instruction word
  input  wire [3:0]  i_flags,      // status flags for condition tests
  output reg         o_valid,      // decoded result valid (pulse)
  output reg  [4:0]  o_class,      // instruction class
  output reg  [2:0]  o_variant,    // class variant bits
  output reg  [2:0]  o_len,        // instruction length in bytes
  output reg         o_illegal,    // opcode not recognised
  output reg         o_byte,       // byte-width operation
  output reg         o_carry,      // uses carry input
  output reg         o_unsigned,   // unsigned multiply/divide
  output reg         o_long_div,   // 32 by 16 long divide
  output reg  [1:0]  o_step,       // register step size for compare
  output reg         o_step_up,    // step is increment
  output reg         o_jump_take,  // branch condition met
  output reg         o_bit_modify, // bit-test branch also modifies bit
  output reg         o_bit_on_set, // bit-test branch jumps on set bit
  output reg  [6:0]  o_trap_num,   // trap vector number
  output reg         o_no_action,  // decoded but has no effect
  output reg         o_ext_open,   // prefix opens extended sequence
  output reg  [1:0]  o_ext_kind,   // prefix kind
  output reg         o_ext_active  // instruction inside extended seq
);

  // ------------------------------------------------------------------
  // field split
  // ------------------------------------------------------------------
  wire [4:0] cls  = i_opword[8+`ILD_CLS_MSB:8+`ILD_CLS_LSB];
  wire [2:0] var3 = i_opword[8+`ILD_VAR_MSB:8+`ILD_VAR_LSB];
  wire [3:0] cc   = i_opword[7:4];
  wire       vlong = var3[`ILD_VAR_LONG];
  wire       vbyte = var3[`ILD_VAR_BYTE];

  // ------------------------------------------------------------------
  // condition evaluation
  // ------------------------------------------------------------------
  reg cond_ok;
  always @* begin
    case (cc)
      `ILD_CC_UC: cond_ok = 1'b1;
      `ILD_CC_Z:  cond_ok = i_flags[`ILD_FLG_Z];
      `ILD_CC_NZ: cond_ok = ~i_flags[`ILD_FLG_Z];
      `ILD_CC_C:  cond_ok = i_flags[`ILD_FLG_C];
      `ILD_CC_NC: cond_ok = ~i_flags[`ILD_FLG_C];
      `ILD_CC_N:  cond_ok = i_flags[`ILD_FLG_N];
      `ILD_CC_NN: cond_ok = ~i_flags[`ILD_FLG_N];
      `ILD_CC_V:  cond_ok = i_flags[`ILD_FLG_V];
      `ILD_CC_NV: cond_ok = ~i_flags[`ILD_FLG_V];
      // undefined codes fail the test; a variant 3 jump or call still branches on one
      default:    cond_ok = 1'b0;
    endcase
  end

  // ------------------------------------------------------------------
  // class decode
  // ------------------------------------------------------------------
  reg [2:0] len_nxt;
  reg       ill_nxt;
  reg       byte_nxt;
  reg       carry_nxt;
  reg       uns_nxt;
  reg       ldiv_nxt;
  reg [1:0] step_nxt;
  reg       up_nxt;
  reg       take_nxt;
  reg       bmod_nxt;
  reg       bset_nxt;
  reg       noact_nxt;
  reg       open_nxt;
  reg [6:0] trap_nxt;
  reg [1:0] kind_nxt;

  always @* begin
    len_nxt   = `ILD_LEN2;
    ill_nxt   = 1'b0;
    byte_nxt  = 1'b0;
    carry_nxt = 1'b0;
    uns_nxt   = 1'b0;
    ldiv_nxt  = 1'b0;
    step_nxt  = 2'h0;
    up_nxt    = 1'b0;
    take_nxt  = 1'b0;
    bmod_nxt  = 1'b0;
    bset_nxt  = 1'b0;
    noact_nxt = 1'b0;
    open_nxt  = 1'b0;
    trap_nxt  = 7'h00;
    kind_nxt  = 2'h0;
    case (cls)
      `ILD_C_ADD, `ILD_C_SUB: begin
        byte_nxt  = vbyte;                                   // RULE_01
        carry_nxt = var3[1];                                 // RULE_01
        len_nxt   = vlong ? `ILD_LEN4 : `ILD_LEN2;           // RULE_01
      end
      `ILD_C_MUL: begin
        uns_nxt = var3[0];                                   // RULE_02
        len_nxt = `ILD_LEN2;
      end
      `ILD_C_DIV: begin
        uns_nxt  = var3[0];                                  // RULE_03
        ldiv_nxt = var3[1];                                  // RULE_04
        len_nxt  = `ILD_LEN2;                                // RULE_03
      end
      `ILD_C_CPLNEG: begin
        byte_nxt = vbyte;                                    // RULE_05
        len_nxt  = `ILD_LEN2;                                // RULE_05
      end
      `ILD_C_AND, `ILD_C_OR, `ILD_C_XOR, `ILD_C_CMP, `ILD_C_MOV: begin
        byte_nxt = vbyte;
        len_nxt  = vlong ? `ILD_LEN4 : `ILD_LEN2;
      end
      `ILD_C_BITCS: begin
        len_nxt = `ILD_LEN2;                                 // RULE_06
      end
      `ILD_C_BITMOV, `ILD_C_BITLOG: begin
        len_nxt = `ILD_LEN4;                                 // RULE_06
      end
      `ILD_C_BFMOD: begin
        len_nxt = `ILD_LEN4;                                 // RULE_07
      end
      `ILD_C_CMPSTEP: begin
        up_nxt   = var3[0];                                  // RULE_08
        step_nxt = var3[1] ? 2'h2 : 2'h1;                    // RULE_08
        len_nxt  = vlong ? `ILD_LEN4 : `ILD_LEN2;            // RULE_08
      end
      `ILD_C_NORM: begin
        len_nxt = `ILD_LEN2;                                 // RULE_09
      end
      `ILD_C_SHIFT: begin
        len_nxt = `ILD_LEN2;                                 // RULE_10
      end
      `ILD_C_MOVEXT: begin
        byte_nxt = 1'b1;                                     // RULE_11
        len_nxt  = vlong ? `ILD_LEN4 : `ILD_LEN2;            // RULE_11
      end
      `ILD_C_JUMP: begin
        // segment jump (variant 3) is unconditional
        take_nxt = (var3[1:0] == 2'h3) ? 1'b1 : cond_ok;     // RULE_12
        len_nxt  = `ILD_LEN4;                                // RULE_12
      end
      `ILD_C_BITJMP: begin
        bset_nxt = ~var3[0];                                 // RULE_13
        bmod_nxt = var3[1];                                  // RULE_13
        len_nxt  = `ILD_LEN4;                                // RULE_13
      end
      `ILD_C_CALL: begin
        take_nxt = (var3[1:0] == 2'h3) ? 1'b1 : cond_ok;
        len_nxt  = `ILD_LEN4;
      end
      `ILD_C_CTXSW: begin
        len_nxt = `ILD_LEN4;                                 // RULE_14
      end
      `ILD_C_PUSHPOP: begin
        len_nxt = `ILD_LEN2;
      end
      `ILD_C_RETURN: begin
        len_nxt = `ILD_LEN2;                                 // RULE_15
      end
      `ILD_C_TRAP: begin
        len_nxt  = `ILD_LEN2;                                // RULE_16
        trap_nxt = i_opword[6:0];                            // RULE_16
      end
      `ILD_C_SYSCTL: begin
        len_nxt   = `ILD_LEN4;                               // RULE_18
        noact_nxt = (var3 == `ILD_SYS_LEGACY_POWERDOWN_OP);                // RULE_18
      end
      `ILD_C_EXTPFX: begin
        open_nxt = 1'b1;                                     // RULE_17
        kind_nxt = var3[1:0];                                // RULE_17
        // only page and segment prefixes have a long form
        len_nxt  = (vlong && !var3[1]) ? `ILD_LEN4 : `ILD_LEN2; // RULE_17
      end
      `ILD_C_NOP: begin
        len_nxt = `ILD_LEN2;
      end
      `ILD_C_COPROC: begin
        len_nxt = `ILD_LEN4;
      end
      default: begin
        // unknown opcodes still advance by 2 so fetch stays aligned
        ill_nxt = 1'b1;
        len_nxt = `ILD_LEN2;                                 // RULE_19
      end
    endcase
  end

  // ------------------------------------------------------------------
  // extended sequence tracker
  // ------------------------------------------------------------------
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_EXT  = 2'b10;

  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [2:0] cnt_r;
  reg [2:0] cnt_nxt;
  reg       in_seq;

  always @* begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    in_seq    = 1'b0;
    case (state_r)
      ST_IDLE: begin
        if (i_valid && open_nxt) begin
          state_nxt = ST_EXT;                                // RULE_17
          cnt_nxt   = {1'b0, i_opword[1:0]} + 3'h1;          // RULE_17
        end
      end
      ST_EXT: begin
        if (i_valid && open_nxt) begin
          // a new prefix restarts the sequence
          cnt_nxt = {1'b0, i_opword[1:0]} + 3'h1;            // RULE_17
        end else if (i_valid) begin
          in_seq  = 1'b1;                                    // RULE_17
          cnt_nxt = cnt_r - 3'h1;
          if (cnt_r == 3'h1) begin
            state_nxt = ST_IDLE;
          end
        end
      end
      default: begin
        state_nxt = ST_IDLE;
        cnt_nxt   = `ILD_RST_CNT;
      end
    endcase
  end

  // ------------------------------------------------------------------
  // sequence tracker registers
  // ------------------------------------------------------------------
  // the tracker moves only on accepted words; idle cycles leave an
  // open window where it was
  always @(posedge i_mclk) begin
    if (i_reset) begin
      state_r <= ST_IDLE;
      cnt_r   <= `ILD_RST_CNT;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  // ------------------------------------------------------------------
  // result pulse
  // ------------------------------------------------------------------
  // fixed one-edge latency, so fetch can advance with no handshake
  always @(posedge i_mclk) begin
    if (i_reset) begin
      o_valid <= 1'b0;
    end else begin
      o_valid <= i_valid;                                  // RULE_19
    end
  end

  // ------------------------------------------------------------------
  // class and length registers
  // ------------------------------------------------------------------
  // fields are held between instructions to save toggling; users
  // must qualify them with the result pulse
  always @(posedge i_mclk) begin
    if (i_reset) begin
      o_class   <= `ILD_RST_CLS;
      o_variant <= 3'h0;
      o_len     <= `ILD_LEN2;
      o_illegal <= 1'b0;
    end else if (i_valid) begin
      o_class   <= cls;
      o_variant <= var3;
      o_len     <= len_nxt;                                // RULE_19
      o_illegal <= ill_nxt;
    end
  end

  // ------------------------------------------------------------------
  // operand attribute registers
  // ------------------------------------------------------------------
  always @(posedge i_mclk) begin
    if (i_reset) begin
      o_byte     <= 1'b0;
      o_carry    <= 1'b0;
      o_unsigned <= 1'b0;
      o_long_div <= 1'b0;
      o_step     <= 2'h0;
      o_step_up  <= 1'b0;
    end else if (i_valid) begin
      o_byte     <= byte_nxt;                              // RULE_01
      o_carry    <= carry_nxt;                             // RULE_01
      o_unsigned <= uns_nxt;                               // RULE_02
      o_long_div <= ldiv_nxt;                              // RULE_04
      o_step     <= step_nxt;                              // RULE_08
      o_step_up  <= up_nxt;                                // RULE_08
    end
  end

  // ------------------------------------------------------------------
  // flow control and sequence registers
  // ------------------------------------------------------------------
  always @(posedge i_mclk) begin
    if (i_reset) begin
      o_jump_take  <= 1'b0;
      o_bit_modify <= 1'b0;
      o_bit_on_set <= 1'b0;
      o_trap_num   <= 7'h00;
      o_no_action  <= 1'b0;
      o_ext_open   <= 1'b0;
      o_ext_kind   <= 2'h0;
      o_ext_active <= 1'b0;
    end else if (i_valid) begin
      o_jump_take  <= take_nxt;                            // RULE_12
      o_bit_modify <= bmod_nxt;                            // RULE_13
      o_bit_on_set <= bset_nxt;                            // RULE_13
      o_trap_num   <= trap_nxt;                            // RULE_16
      o_no_action  <= noact_nxt;                           // RULE_18
      o_ext_open   <= open_nxt;                            // RULE_17
      o_ext_kind   <= kind_nxt;                            // RULE_17
      o_ext_active <= in_seq;                              // RULE_17
    end
  end

endmodule // ild_decoder

// ==== ild_decoder_chk.sv ====
// port assertions for the instruction length decoder
`timescale 1ns/1ns
module ild_decoder_chk (
  input wire        i_mclk,       // clock
  input wire        i_reset,      // sync reset
  input wire        i_valid,      // opcode present
  input wire [15:0] i_opword,     // opcode word
  input wire [3:0]  i_flags,      // status flags
  input wire        o_valid,      // result pulse
  input wire [2:0]  o_len,        // length
  input wire        o_jump_take,  // branch taken
  input wire [6:0]  o_trap_num,   // trap number
  input wire        o_no_action,  // no effect
  input wire        o_ext_active  // inside sequence
);
  wire [4:0] cls = i_opword[15:11];
  wire [2:0] vb  = i_opword[10:8];

  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_reset);

  // --------------------------------------------------------------
  // prefix sequences
  // --------------------------------------------------------------
  // a one-instruction window, so the second plain op falls outside
  sequence s_pfx_one;
    i_valid && cls == 5'h1A && i_opword[1:0] == 2'h0;
  endsequence
  sequence s_plain;
    i_valid && cls != 5'h1A;
  endsequence

  a_valid_follow: assert property (i_valid |=> o_valid)
    else $error("no result pulse");
  a_len_legal: assert property (o_valid |-> o_len inside {2, 4})
    else $error("bad length");
  a_fixed_four: assert property (i_valid && cls inside
    {5'h09, 5'h0A, 5'h0B, 5'h12, 5'h13, 5'h15} |=> o_len == 3'h4)
    else $error("length not four");
  a_fixed_two: assert property (i_valid && cls inside
    {5'h03, 5'h04, 5'h08, 5'h0E, 5'h0F, 5'h17, 5'h18} |=> o_len == 3'h2)
    else $error("length not two");
  a_long_form: assert property (i_valid && cls inside
    {5'h00, 5'h01, 5'h0D, 5'h11} |=>
    o_len == ($past(i_opword[10]) ? 3'h4 : 3'h2))
    else $error("short/long form length");
  a_legacy_powerdown_op_quiet: assert property (i_valid && cls == 5'h19 &&
    vb == 3'h2 |=> o_no_action && o_len == 3'h4)
    else $error("legacy op not quiet");
  a_jump_false: assert property (i_valid && cls == 5'h12 &&
    vb[1:0] != 2'h3 && i_opword[7:4] == 4'h1 && !i_flags[0]
    |=> !o_jump_take)
    else $error("jump taken on false condition");
  a_trap_number: assert property (i_valid && cls == 5'h18
    |=> o_trap_num == $past(i_opword[6:0]))
    else $error("trap number lost");
  a_ext_enter: assert property (s_pfx_one ##1 s_plain
    |=> o_ext_active)
    else $error("sequence not opened");
  a_ext_leave: assert property (s_pfx_one ##1 s_plain
    ##1 s_plain |=> !o_ext_active)
    else $error("sequence overran");
endmodule // ild_decoder_chk

bind ild_decoder ild_decoder_chk u_chk (.i_mclk, .i_reset, .i_valid,
  .i_opword, .i_flags, .o_valid, .o_len, .o_jump_take, .o_trap_num,
  .o_no_action, .o_ext_active);

// ==== ild_fetch_model.sv ====
// fetch-side model: moves the instruction pointer by decoded lengths
`timescale 1ns/1ns
module ild_fetch_model (
  input  wire        i_mclk,   // clock
  input  wire        i_reset,  // sync reset
  input  wire        i_dvalid, // decoded pulse
  input  wire [2:0]  i_len,    // bytes to advance
  output reg  [15:0] o_ip      // instruction pointer
);
  always @(posedge i_mclk) begin
    if (i_reset)
      o_ip <= 16'h0000;
    else if (i_dvalid)
      o_ip <= o_ip + {13'h0000, i_len};
  end
endmodule // ild_fetch_model

// ==== test_ild_decoder.sv ====
// self-checking bench for the instruction length decoder
`timescale 1ns/1ns
module test_ild_decoder;
  reg          i_mclk = 1'b0;
  reg          i_reset = 1'b1;
  reg          i_valid = 1'b0;
  reg  [15:0]  i_opword = 16'h0000;
  reg  [3:0]   i_flags = 4'h0;
  wire         o_valid, o_illegal, o_byte, o_carry, o_unsigned;
  wire         o_long_div, o_step_up, o_jump_take, o_bit_modify;
  wire         o_bit_on_set, o_no_action, o_ext_open, o_ext_active;
  wire [4:0]   o_class;
  wire [2:0]   o_len, o_variant;
  wire [1:0]   o_step, o_ext_kind;
  wire [6:0]   o_trap_num;
  wire [15:0]  ip;
  integer      seed = 32'h7E51388E;
  integer      num_errors = 0;
  integer      checks = 0;
  integer      cnt, n;
  reg          p_v;
  reg  [15:0]  p_op, op, ip_exp;
  reg  [3:0]   p_fl;
  // prefix window of one, jumps, legacy op, then an unknown class
  localparam [159:0] LIST = {16'hD000, 16'h0000, 16'h0400, 16'h9010,
    16'h9300, 16'hCA05, 16'hAE00, 16'hE000, 16'hE800, 16'h0000};

  always #2 i_mclk = ~i_mclk;

  ild_decoder dut (.i_mclk, .i_reset, .i_valid, .i_opword, .i_flags,
    .o_valid, .o_class, .o_variant, .o_len, .o_illegal, .o_byte,
    .o_carry, .o_unsigned, .o_long_div, .o_step, .o_step_up,
    .o_jump_take, .o_bit_modify, .o_bit_on_set, .o_trap_num,
    .o_no_action, .o_ext_open, .o_ext_kind, .o_ext_active);
  ild_fetch_model u_fetch (.i_mclk, .i_reset, .i_dvalid(o_valid),
    .i_len(o_len), .o_ip(ip));

  // ------------------------------------------------------------
  // expectations
  // ------------------------------------------------------------
  // zero marks a length the opcode map leaves open
  function [2:0] exp_len(input [15:0] o);
    case (o[15:11])
      5'h00, 5'h01, 5'h05, 5'h06, 5'h07, 5'h0C, 5'h0D, 5'h10, 5'h11:
        exp_len = o[10] ? 3'h4 : 3'h2;
      5'h09, 5'h0A, 5'h0B, 5'h12, 5'h13, 5'h14, 5'h15, 5'h1C:
        exp_len = 3'h4;
      5'h19: exp_len = (o[10:8] == 3'h2) ? 3'h4 : 3'h0;
      5'h1A: exp_len = (o[10] && !o[9]) ? 3'h4 : 3'h2;
      5'h02: exp_len = 3'h0;
      default: exp_len = 3'h2;
    endcase
  endfunction

  // odd codes test a flag, the even code after it tests its inverse
  function exp_take(input [15:0] o, input [3:0] f);
    reg [3:0] k;
    begin
      k = o[7:4] - 4'h1;
      exp_take = (o[9:8] == 2'h3 || o[7:4] == 4'h0) ? 1'b1 :
                 (o[7:4] > 4'h8) ? 1'b0 : f[k[2:1]] ^ k[0];
    end
  endfunction

  task check(input [31:0] seen, input [31:0] want);
    begin
      checks = checks + 1;
      if (seen !== want) begin
        num_errors = num_errors + 1;
        $display("wrong value at %0t: %h vs %h", $time, seen, want);
      end
    end
  endtask

  task tally_and_finish;
    begin
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask

  task do_reset;
    begin
      @(negedge i_mclk);
      i_reset = 1'b1;
      i_valid = 1'b0;
      p_v = 1'b0;
      cnt = 0;
      ip_exp = 16'h0000;
      repeat (6) @(negedge i_mclk);
      i_reset = 1'b0;
      check({o_valid, o_class, o_len}, {1'b0, 5'h1B, 3'h2});
    end
  endtask

  // ------------------------------------------------------------
  // one cycle: judge the previous instruction, present the next
  // ------------------------------------------------------------
  task step(input v, input [15:0] o, input [3:0] f);
    reg [4:0] c;
    reg [2:0] w;
    begin
      @(negedge i_mclk);
      check(o_valid, p_v);
      c = p_op[15:11];
      w = p_op[10:8];
      if (p_v) begin
        ip_exp = ip_exp + exp_len(p_op);
        check({o_class, o_variant}, p_op[15:8]);
        if (exp_len(p_op) != 3'h0)
          check(o_len, exp_len(p_op));
        if (c < 5'h02)
          check({o_byte, o_carry}, {w[0], w[1]});
        if (c == 5'h02 || c == 5'h03)
          check(o_unsigned, w[0]);
        if (c == 5'h03)
          check(o_long_div, w[1]);
        if (c == 5'h04)
          check(o_byte, w[0]);
        if (c == 5'h11)
          check(o_byte, 1'b1);
        if (c == 5'h0D)
          check({o_step, o_step_up}, {w[1], ~w[1], w[0]});
        if (c == 5'h12)
          check(o_jump_take, exp_take(p_op, p_fl));
        if (c == 5'h13)
          check({o_bit_on_set, o_bit_modify}, {~w[0], w[1]});
        if (c == 5'h18)
          check(o_trap_num, p_op[6:0]);
        check(o_no_action, c == 5'h19 && w == 3'h2);
        check(o_illegal, c >= 5'h1D);
        if (c == 5'h1A) begin
          check({o_ext_open, o_ext_kind, o_ext_active},
                {1'b1, w[1:0], 1'b0});
          cnt = p_op[1:0] + 1;
        end else begin
          check({o_ext_open, o_ext_active}, {1'b0, cnt != 0});
          if (cnt != 0)
            cnt = cnt - 1;
        end
      end
      i_valid = v;
      i_opword = o;
      i_flags = f;
      p_v = v;
      if (v) begin
        p_op = o;
        p_fl = f;
      end
    end
  endtask

  // unknown classes stay out of the random mix: their effect on an
  // open prefix window is not defined
  initial begin
    do_reset;
    for (n = 0; n < 400; n = n + 1) begin
      op = $random(seed);
      op[15:11] = $unsigned($random(seed)) % 29;
      step(($random(seed) & 7) != 0, op, $random(seed));
    end
    do_reset;
    for (n = 0; n < 9; n = n + 1)
      step(1'b1, LIST[159 - 16 * n -: 16], 4'h0);
    step(1'b0, 16'h0000, 4'h0);
    step(1'b0, 16'h0000, 4'h0);
    check(ip, ip_exp);
    tally_and_finish;
  end

  // about 430 cycles are needed; twelve times that means a hang
  initial begin
    #20000;
    num_errors = num_errors + 1;
    tally_and_finish;
  end
endmodule // test_ild_decoder
